// [amu_pkg.sv]
// Purpose: shared widths, addresses, reset values and types of the
//          operand and transfer address unit
// Assumes: one instruction-cycle clock, memories answer one cycle late
// Notes:   the pointer registers live in the core, not in the data memory
`default_nettype none

package amu_pkg;

    localparam int DATA_W  = 8;
    localparam int PC_W    = 15;
    localparam int PC_HI_W = 7;
    localparam int SEG_W   = 12;
    localparam int SHORT_W = 4;
    localparam int REL_W   = 7;

    // register memory page and the cells that hold the pointers
    localparam logic [3:0]        REG_PAGE        = 4'hf;
    localparam logic [DATA_W-1:0] ADDR_SECOND_PTR = 8'hfc;
    localparam logic [DATA_W-1:0] ADDR_STACK_PTR  = 8'hfd;
    localparam logic [DATA_W-1:0] ADDR_FIRST_PTR  = 8'hfe;

    // relative displacement window and the one value that is no jump
    localparam logic signed [REL_W-1:0] REL_MIN = 7'h61;
    localparam logic signed [REL_W-1:0] REL_MAX = 7'h20;
    localparam logic signed [REL_W-1:0] REL_NOP = 7'h01;

    localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
    localparam logic [DATA_W-1:0] RST_PTR = 8'h00;
    localparam logic [DATA_W-1:0] RST_SP  = 8'h2f;
    localparam logic [PC_W-1:0]   RST_PC  = 15'h0000;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_PTR_LOAD,
        OP_PTR_SWAP,
        OP_DIRECT_LOAD,
        OP_REG_LOAD,
        OP_IMM_LOAD,
        OP_SHORT_IMM,
        OP_TABLE_READ,
        OP_REL_JUMP,
        OP_ABS_JUMP,
        OP_ABS_CALL,
        OP_LONG_JUMP,
        OP_LONG_CALL,
        OP_IND_JUMP,
        OP_VECTOR
    } amu_op_t;

    typedef struct packed {
        amu_op_t         op;
        logic            ptr_second;
        logic            auto_step;
        logic            step_down;
        logic [PC_W-1:0] field;
    } amu_cmd_t;

    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic global_irq_enable;
    } amu_psw_t;

    typedef struct packed {
        logic [DATA_W-1:0] addr;
        logic              rd;
        logic              wr;
        logic [DATA_W-1:0] wdata;
    } amu_dmem_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DATA,
        ST_PDATA,
        ST_PUSH,
        ST_VEC_HI,
        ST_VEC_LO
    } amu_state_t;

endpackage

`default_nettype wire

// [amu_ptr_step.sv]
// Purpose: one step up or down of an 8-bit pointer
// Assumes: wraps modulo 256
// Notes:   purely combinational
`default_nettype none

module amu_ptr_step #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] value_i,
    input  wire logic         down_i,
    output logic      [W-1:0] value_o
);

    assign value_o = down_i ? value_i - W'(1) : value_i + W'(1);

endmodule

`default_nettype wire

// [amu_core.sv]
// Purpose: operand and control-transfer address generation of the core
// Assumes: data and program memory return read data one cycle after rd
// Notes:   one command at a time; acc and counter writes only while idle, psw writes in any state
`default_nettype none

module amu_core
    import amu_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 req_valid_i,
    input  wire amu_cmd_t             req_cmd_i,
    output logic                      req_ready_o,
    output logic                      done_o,
    output logic      [DATA_W-1:0]    operand_o,
    input  wire logic                 acc_wr_i,
    input  wire logic [DATA_W-1:0]    acc_wdata_i,
    input  wire logic                 psw_wr_i,
    input  wire amu_psw_t             psw_wdata_i,
    input  wire logic                 pc_wr_i,
    input  wire logic [PC_W-1:0]      pc_wdata_i,
    output amu_dmem_req_t             dmem_req_o,
    input  wire logic [DATA_W-1:0]    dmem_rdata_i,
    output logic      [PC_W-1:0]      pmem_addr_o,
    output logic                      pmem_rd_o,
    input  wire logic [DATA_W-1:0]    pmem_rdata_i,
    output logic      [DATA_W-1:0]    acc_o,
    output logic      [DATA_W-1:0]    first_ptr_o,
    output logic      [DATA_W-1:0]    second_ptr_o,
    output logic      [DATA_W-1:0]    stack_ptr_o,
    output logic      [PC_W-1:0]      pc_o,
    output amu_psw_t                  psw_o
);

    amu_state_t          state_q, state_d;
    amu_cmd_t            cmd_q, cmd_d;
    logic [DATA_W-1:0]   acc_q, acc_d;
    logic [DATA_W-1:0]   first_q, first_d;
    logic [DATA_W-1:0]   second_q, second_d;
    logic [DATA_W-1:0]   sp_q, sp_d;
    logic [PC_W-1:0]     pc_q, pc_d;
    amu_psw_t            psw_q, psw_d;
    logic [DATA_W-1:0]   operand_q, operand_d;
    logic                done_q, done_d;
    amu_dmem_req_t       dmem_d;
    logic                pmem_rd_d;

    // counter halves
    wire logic [PC_HI_W-1:0] pc_high = pc_q[PC_W-1:DATA_W];
    wire logic [DATA_W-1:0]  pc_low  = pc_q[DATA_W-1:0];

    // operand address decode
    wire logic is_ptr  = (cmd_q.op == OP_PTR_LOAD) ||
                         (cmd_q.op == OP_PTR_SWAP);
    wire logic is_swap = (cmd_q.op == OP_PTR_SWAP);
    wire logic is_reg  = (cmd_q.op == OP_REG_LOAD);
    wire logic is_dir  = (cmd_q.op == OP_DIRECT_LOAD);
    wire logic is_call = (cmd_q.op == OP_ABS_CALL) ||
                         (cmd_q.op == OP_LONG_CALL);
    wire logic uses_dmem = is_ptr || is_reg || is_dir;

    wire logic [DATA_W-1:0] ptr_val =
        cmd_q.ptr_second ? second_q : first_q;
    wire logic [DATA_W-1:0] reg_addr =
        {REG_PAGE, cmd_q.field[SHORT_W-1:0]};
    wire logic [DATA_W-1:0] dm_addr =
        is_ptr ? ptr_val :
        is_reg ? reg_addr :
        cmd_q.field[DATA_W-1:0];

    // pointer cells answer from here, the memory never sees them
    wire logic hit_first  = (dm_addr == ADDR_FIRST_PTR);
    wire logic hit_second = (dm_addr == ADDR_SECOND_PTR);
    wire logic hit_sp     = (dm_addr == ADDR_STACK_PTR);
    wire logic int_hit    = hit_first || hit_second || hit_sp;
    wire logic [DATA_W-1:0] int_val =
        hit_first  ? first_q :
        hit_second ? second_q : sp_q;

    // post step of the selected pointer
    logic [DATA_W-1:0] first_step;
    logic [DATA_W-1:0] second_step;
    wire logic step_first  = is_ptr && cmd_q.auto_step &&
                             !cmd_q.ptr_second;
    wire logic step_second = is_ptr && cmd_q.auto_step &&
                             cmd_q.ptr_second;

    amu_ptr_step #(.W(DATA_W)) u_step_first (
        .value_i (first_q),
        .down_i  (cmd_q.step_down),
        .value_o (first_step)
    );

    amu_ptr_step #(.W(DATA_W)) u_step_second (
        .value_i (second_q),
        .down_i  (cmd_q.step_down),
        .value_o (second_step)
    );

    // relative target; a wrap over 15 bits is intended, no pages
    wire logic signed [REL_W-1:0] disp = cmd_q.field[REL_W-1:0];
    wire logic rel_ok = (disp >= REL_MIN) && (disp <= REL_MAX) &&
                        (disp != REL_NOP);
    wire logic [PC_W-1:0] rel_target =
        pc_q + {{(PC_W-REL_W){disp[REL_W-1]}}, disp};
    wire logic [PC_W-1:0] seg_target =
        {pc_q[PC_W-1:SEG_W], cmd_q.field[SEG_W-1:0]};
    wire logic [PC_W-1:0] call_target =
        (cmd_q.op == OP_LONG_CALL) ? cmd_q.field : seg_target;

    // program memory address: table lookups keep the high part
    wire logic [PC_W-1:0] tbl_addr  = {pc_high, acc_q};
    wire logic [PC_W-1:0] vec_next  = cmd_q.field + PC_W'(1);
    assign pmem_addr_o =
        (state_q == ST_VEC_HI)     ? vec_next :
        (cmd_q.op == OP_VECTOR)    ? cmd_q.field : tbl_addr;

    always_comb begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        acc_d     = acc_q;
        first_d   = first_q;
        second_d  = second_q;
        sp_d      = sp_q;
        pc_d      = pc_q;
        psw_d     = psw_q;
        operand_d = operand_q;
        done_d    = 1'b0;
        pmem_rd_d = 1'b0;
        dmem_d    = '0;
        dmem_d.addr  = dm_addr;
        dmem_d.wdata = acc_q;
        if (psw_wr_i) begin
            psw_d = psw_wdata_i;
        end
        case (state_q)
            ST_IDLE: begin
                if (acc_wr_i) begin
                    acc_d = acc_wdata_i;
                end
                if (pc_wr_i) begin
                    pc_d = pc_wdata_i;
                end
                if (req_valid_i) begin
                    cmd_d   = req_cmd_i;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                state_d = ST_IDLE;
                done_d  = 1'b1;
                case (cmd_q.op)
                    OP_PTR_LOAD, OP_PTR_SWAP, OP_DIRECT_LOAD,
                    OP_REG_LOAD: begin
                        if (int_hit) begin
                            operand_d = int_val;
                            acc_d     = int_val;
                            if (is_swap && hit_first) begin
                                first_d = acc_q;
                            end
                            if (is_swap && hit_second) begin
                                second_d = acc_q;
                            end
                            if (is_swap && hit_sp) begin
                                sp_d = acc_q;
                            end
                            if (step_first) begin
                                first_d = first_step;
                            end
                            if (step_second) begin
                                second_d = second_step;
                            end
                        end else begin
                            dmem_d.rd = 1'b1;
                            done_d    = 1'b0;
                            state_d   = ST_DATA;
                        end
                    end
                    OP_IMM_LOAD: begin
                        operand_d = cmd_q.field[DATA_W-1:0];
                        acc_d     = cmd_q.field[DATA_W-1:0];
                    end
                    OP_SHORT_IMM: begin
                        operand_d = {{(DATA_W-SHORT_W){1'b0}},
                                     cmd_q.field[SHORT_W-1:0]};
                        first_d   = {{(DATA_W-SHORT_W){1'b0}},
                                     cmd_q.field[SHORT_W-1:0]};
                    end
                    OP_TABLE_READ, OP_IND_JUMP: begin
                        pmem_rd_d = 1'b1;
                        done_d    = 1'b0;
                        state_d   = ST_PDATA;
                    end
                    OP_REL_JUMP: begin
                        if (rel_ok) begin
                            pc_d = rel_target;
                        end
                    end
                    OP_ABS_JUMP: begin
                        pc_d = seg_target;
                    end
                    OP_LONG_JUMP: begin
                        pc_d = cmd_q.field;
                    end
                    OP_ABS_CALL, OP_LONG_CALL: begin
                        dmem_d.addr  = sp_q;
                        dmem_d.wdata = pc_low;
                        dmem_d.wr    = 1'b1;
                        done_d       = 1'b0;
                        state_d      = ST_PUSH;
                    end
                    OP_VECTOR: begin
                        pmem_rd_d = 1'b1;
                        done_d    = 1'b0;
                        state_d   = ST_VEC_HI;
                    end
                    default: begin
                    end
                endcase
            end
            ST_DATA: begin
                operand_d = dmem_rdata_i;
                acc_d     = dmem_rdata_i;
                if (is_swap) begin
                    dmem_d.wr = 1'b1;
                end
                if (step_first) begin
                    first_d = first_step;
                end
                if (step_second) begin
                    second_d = second_step;
                end
                done_d  = 1'b1;
                state_d = ST_IDLE;
            end
            ST_PDATA: begin
                operand_d = pmem_rdata_i;
                if (cmd_q.op == OP_IND_JUMP) begin
                    pc_d = {pc_high, pmem_rdata_i};
                end else begin
                    acc_d = pmem_rdata_i;
                end
                done_d  = 1'b1;
                state_d = ST_IDLE;
            end
            ST_PUSH: begin
                dmem_d.addr  = sp_q - DATA_W'(1);
                dmem_d.wdata = {1'b0, pc_high};
                dmem_d.wr    = 1'b1;
                sp_d         = sp_q - DATA_W'(2);
                pc_d         = call_target;
                done_d       = 1'b1;
                state_d      = ST_IDLE;
            end
            ST_VEC_HI: begin
                pc_d[PC_W-1:DATA_W] = pmem_rdata_i[PC_HI_W-1:0];
                pmem_rd_d = 1'b1;
                state_d   = ST_VEC_LO;
            end
            ST_VEC_LO: begin
                pc_d[DATA_W-1:0] = pmem_rdata_i;
                done_d  = 1'b1;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q   <= ST_IDLE;
            cmd_q     <= '0;
            acc_q     <= RST_ACC;
            first_q   <= RST_PTR;
            second_q  <= RST_PTR;
            sp_q      <= RST_SP;
            pc_q      <= RST_PC;
            psw_q     <= '0;
            operand_q <= '0;
            done_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            cmd_q     <= cmd_d;
            acc_q     <= acc_d;
            first_q   <= first_d;
            second_q  <= second_d;
            sp_q      <= sp_d;
            pc_q      <= pc_d;
            psw_q     <= psw_d;
            operand_q <= operand_d;
            done_q    <= done_d;
        end
    end

    // memory strobes are decoded from registered state only
    assign dmem_req_o   = dmem_d;
    assign pmem_rd_o    = pmem_rd_d;
    assign req_ready_o  = (state_q == ST_IDLE);
    assign done_o       = done_q;
    assign operand_o    = operand_q;
    assign acc_o        = acc_q;
    assign first_ptr_o  = first_q;
    assign second_ptr_o = second_q;
    assign stack_ptr_o  = sp_q;
    assign pc_o         = pc_q;
    assign psw_o        = psw_q;

endmodule

`default_nettype wire

// [amu_core_monitor.sv]
// Purpose: concurrent checks on the address unit ports
// Assumes: memories answer one cycle after each read strobe
// Notes:   delays count edges from the accepting edge
`default_nettype none

module amu_core_monitor
    import amu_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              req_valid_i,
    input  wire amu_cmd_t          req_cmd_i,
    input  wire logic              req_ready_o,
    input  wire logic              done_o,
    input  wire logic [DATA_W-1:0] operand_o,
    input  wire logic [PC_W-1:0]   pmem_addr_o,
    input  wire logic              pmem_rd_o,
    input  wire logic [DATA_W-1:0] pmem_rdata_i,
    input  wire logic [DATA_W-1:0] acc_o,
    input  wire logic [DATA_W-1:0] first_ptr_o,
    input  wire logic [PC_W-1:0]   pc_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    wire logic signed [REL_W-1:0]  rel_d = req_cmd_i.field[REL_W-1:0];
    wire logic                     rel_ok = rel_d >= REL_MIN
                                   && rel_d <= REL_MAX && rel_d != REL_NOP;
    wire logic [PC_W-1:0]          rel_ext = PC_W'(rel_d);
    wire logic [PC_W-1:0]          tab_a = {pc_o[PC_W-1:DATA_W], acc_o};
    wire logic [PC_W-1:0]          abs_t = {pc_o[PC_W-1:SEG_W],
                                            req_cmd_i.field[SEG_W-1:0]};
    wire logic [PC_HI_W-1:0]       rom7 = pmem_rdata_i[PC_HI_W-1:0];

    sequence s_take(amu_op_t op);
        req_valid_i && req_ready_o && req_cmd_i.op == op;
    endsequence

    sequence s_rom_rd(logic [PC_W-1:0] a);
        pmem_rd_o && pmem_addr_o == a;
    endsequence

    a_imm_operand: assert property (s_take(OP_IMM_LOAD) |-> ##2
        done_o && operand_o == $past(req_cmd_i.field[DATA_W-1:0], 2))
        else $error("immediate operand wrong");
    a_short_imm: assert property (s_take(OP_SHORT_IMM) |-> ##2
        first_ptr_o == {4'h0, $past(req_cmd_i.field[SHORT_W-1:0], 2)})
        else $error("short immediate pointer wrong");
    a_long_target: assert property (s_take(OP_LONG_JUMP) |-> ##2
        done_o && pc_o == $past(req_cmd_i.field, 2))
        else $error("long jump target wrong");
    a_abs_segment: assert property (s_take(OP_ABS_JUMP) |-> ##2
        pc_o == $past(abs_t, 2))
        else $error("absolute jump left the segment");
    a_rel_target: assert property (s_take(OP_REL_JUMP) ##0 rel_ok
        |-> ##2 pc_o == $past(pc_o, 2) + $past(rel_ext, 2))
        else $error("relative jump target wrong");
    a_rel_noop: assert property (s_take(OP_REL_JUMP) ##0 !rel_ok
        |-> ##2 done_o && pc_o == $past(pc_o, 2))
        else $error("refused displacement moved the counter");
    a_table_addr: assert property (s_take(OP_TABLE_READ) |-> ##1
        s_rom_rd(tab_a))
        else $error("table read address wrong");
    a_ind_jump: assert property (s_take(OP_IND_JUMP) |-> ##1
        s_rom_rd(tab_a) ##2 done_o
        && pc_o == {$past(pc_o[PC_W-1:DATA_W], 2), $past(pmem_rdata_i)})
        else $error("indirect jump target wrong");
    a_vector_fetch: assert property (s_take(OP_VECTOR) |-> ##1
        s_rom_rd($past(req_cmd_i.field)) ##1
        s_rom_rd($past(req_cmd_i.field, 2) + 15'h0001) ##2 done_o
        && pc_o == {$past(rom7, 2), $past(pmem_rdata_i)})
        else $error("vector dispatch wrong");
endmodule

bind amu_core amu_core_monitor u_amu_core_monitor (
    .clk_sys_i, .rst_n_i, .req_valid_i, .req_cmd_i, .req_ready_o, .done_o,
    .operand_o, .pmem_addr_o, .pmem_rd_o, .pmem_rdata_i, .acc_o,
    .first_ptr_o, .pc_o
);

`default_nettype wire

// [amu_mem_model.sv]
// Purpose: data and program memory beside the address unit
// Assumes: reads answer one cycle after the strobe
// Notes:   program bytes follow a fixed address pattern
`default_nettype none

module amu_mem_model
    import amu_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire amu_dmem_req_t     dmem_req_i,
    output logic      [DATA_W-1:0] dmem_rdata_o,
    input  wire logic [PC_W-1:0]   pmem_addr_i,
    input  wire logic              pmem_rd_i,
    output logic      [DATA_W-1:0] pmem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] dmem [256];

    function automatic logic [DATA_W-1:0] rom(input logic [PC_W-1:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5a;
    endfunction

    initial begin
        foreach (dmem[i]) begin
            dmem[i] = 8'(i) ^ 8'hc3;
        end
        dmem_rdata_o = 8'h00;
        pmem_rdata_o = 8'h00;
    end

    // idle buses flip every cycle so stale data never passes for an answer
    always @(posedge clk_sys_i) begin
        if (dmem_req_i.wr) begin
            dmem[dmem_req_i.addr] <= dmem_req_i.wdata;
        end
        dmem_rdata_o <= dmem_req_i.rd ? dmem[dmem_req_i.addr]
                                      : ~dmem_rdata_o;
        pmem_rdata_o <= pmem_rd_i ? rom(pmem_addr_i) : ~pmem_rdata_o;
    end
endmodule

`default_nettype wire

// [amu_core_test.sv]
// Purpose: directed checks of the address unit with a memory model
// Assumes: memory model answers one cycle after each read strobe
// Notes:   latency is counted in edges after the accepting edge
`default_nettype none

module amu_core_test
    import amu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk_sys_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              req_valid_i = 1'b0;
    amu_cmd_t          req_cmd_i = '0;
    logic              acc_wr_i = 1'b0;
    logic [DATA_W-1:0] acc_wdata_i = '0;
    logic              psw_wr_i = 1'b0;
    amu_psw_t          psw_wdata_i = '0;
    logic              pc_wr_i = 1'b0;
    logic [PC_W-1:0]   pc_wdata_i = '0;
    logic              req_ready_o, done_o, pmem_rd_o;
    logic [DATA_W-1:0] operand_o, dmem_rdata_i, pmem_rdata_i, acc_o;
    logic [DATA_W-1:0] first_ptr_o, second_ptr_o, stack_ptr_o;
    logic [PC_W-1:0]   pc_o, pmem_addr_o;
    amu_dmem_req_t     dmem_req_o;
    amu_psw_t          psw_o;
    int                mismatches = 0;
    int                total_checks = 0;

    amu_core u_amu_core (
        .clk_sys_i, .rst_n_i, .req_valid_i, .req_cmd_i, .req_ready_o,
        .done_o, .operand_o, .acc_wr_i, .acc_wdata_i, .psw_wr_i,
        .psw_wdata_i, .pc_wr_i, .pc_wdata_i, .dmem_req_o, .dmem_rdata_i,
        .pmem_addr_o, .pmem_rd_o, .pmem_rdata_i, .acc_o, .first_ptr_o,
        .second_ptr_o, .stack_ptr_o, .pc_o, .psw_o
    );

    amu_mem_model u_mem (
        .clk_sys_i(clk_sys_i), .dmem_req_i(dmem_req_o),
        .dmem_rdata_o(dmem_rdata_i), .pmem_addr_i(pmem_addr_o),
        .pmem_rd_i(pmem_rd_o), .pmem_rdata_o(pmem_rdata_i)
    );

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [7:0] rom(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5a;
    endfunction

    task automatic cmp8(input string what, input logic [7:0] e,
                        input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp15(input string what, input logic [14:0] e,
                         input logic [14:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    // m is {ptr_second, auto_step, step_down}
    task automatic run(input amu_op_t op, input logic [14:0] f,
                       input logic [2:0] m, input logic [7:0] lat);
        int n;
        @(posedge clk_sys_i);
        req_cmd_i <= '{op, m[2], m[1], m[0], f};
        req_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
        #1;
        cmp8("ready while busy", 8'h00, 8'(req_ready_o));
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
            #1;
        end while (done_o !== 1'b1 && n < 8);
        // done shows just after an edge and is taken at the next one
        cmp8("latency", lat, 8'(n + 1));
        cmp8("ready when done", 8'h01, 8'(req_ready_o));
    endtask

    // acc and counter writes are only honoured while idle
    task automatic set_regs(input logic [7:0] a, input logic [14:0] p);
        @(posedge clk_sys_i);
        acc_wr_i <= 1'b1;
        acc_wdata_i <= a;
        pc_wr_i <= 1'b1;
        pc_wdata_i <= p;
        @(posedge clk_sys_i);
        acc_wr_i <= 1'b0;
        pc_wr_i <= 1'b0;
        #1;
    endtask

    task automatic t_ptr();
        run(OP_SHORT_IMM, 15'h0007, 3'b000, 8'd2);
        cmp8("first_ptr", 8'h07, first_ptr_o);
        cmp8("operand", 8'h07, operand_o);
        run(OP_PTR_LOAD, 15'h0000, 3'b010, 8'd3);
        cmp8("acc", 8'h07 ^ 8'hc3, acc_o);
        cmp8("first_ptr", 8'h08, first_ptr_o);
        run(OP_PTR_LOAD, 15'h0000, 3'b111, 8'd3);
        cmp8("acc", 8'hc3, acc_o);
        cmp8("second_ptr", 8'hff, second_ptr_o);
        run(OP_PTR_SWAP, 15'h0000, 3'b000, 8'd3);
        cmp8("acc", 8'h08 ^ 8'hc3, acc_o);
        cmp8("swapped cell", 8'hc3, u_mem.dmem[8]);
    endtask

    task automatic t_mem();
        run(OP_DIRECT_LOAD, 15'h0033, 3'b000, 8'd3);
        cmp8("acc", 8'h33 ^ 8'hc3, acc_o);
        run(OP_DIRECT_LOAD, 15'h00fd, 3'b000, 8'd2);
        cmp8("acc", 8'h2f, acc_o);
        run(OP_REG_LOAD, 15'h0003, 3'b000, 8'd3);
        cmp8("acc", 8'hf3 ^ 8'hc3, acc_o);
        run(OP_IMM_LOAD, 15'h00a5, 3'b000, 8'd2);
        cmp8("operand", 8'ha5, operand_o);
        @(posedge clk_sys_i);
        psw_wr_i <= 1'b1;
        psw_wdata_i <= 3'b101;
        @(posedge clk_sys_i);
        psw_wr_i <= 1'b0;
        #1;
        cmp8("psw", 8'h05, 8'(psw_o));
    endtask

    task automatic t_rom();
        logic [7:0] v;
        // high part chosen so the table byte differs from the accumulator
        set_regs(8'h4c, 15'h3a12);
        run(OP_TABLE_READ, 15'h0000, 3'b000, 8'd3);
        cmp8("acc", rom(15'h3a4c), acc_o);
        cmp15("pc", 15'h3a12, pc_o);
        set_regs(8'h4c, 15'h3a12);
        run(OP_IND_JUMP, 15'h0000, 3'b000, 8'd3);
        cmp15("pc", {7'h3a, rom(15'h3a4c)}, pc_o);
        v = rom(15'h0040);
        run(OP_VECTOR, 15'h0040, 3'b000, 8'd4);
        cmp15("pc", {v[6:0], rom(15'h0041)}, pc_o);
    endtask

    task automatic t_rel();
        logic [6:0] d [6] = '{7'h20, 7'h61, 7'h01, 7'h21, 7'h60, 7'h7f};
        int s;
        logic [14:0] e;
        foreach (d[i]) begin
            s = d[i];
            s = s > 63 ? s - 128 : s;
            e = (s >= -31 && s <= 32 && s != 1) ? 15'h0010 + 15'(s)
                                                : 15'h0010;
            set_regs(8'h00, 15'h0010);
            run(OP_REL_JUMP, {8'h00, d[i]}, 3'b000, 8'd2);
            cmp15("rel target", e, pc_o);
        end
    endtask

    task automatic t_abs();
        set_regs(8'h00, 15'h3abc);
        run(OP_ABS_JUMP, 15'h0123, 3'b000, 8'd2);
        cmp15("pc", 15'h3123, pc_o);
        run(OP_ABS_CALL, 15'h0456, 3'b000, 8'd3);
        cmp15("pc", 15'h3456, pc_o);
        cmp8("push low", 8'h23, u_mem.dmem[8'h2f]);
        cmp8("push high", 8'h31, u_mem.dmem[8'h2e]);
        run(OP_LONG_JUMP, 15'h6789, 3'b000, 8'd2);
        cmp15("pc", 15'h6789, pc_o);
        run(OP_LONG_CALL, 15'h7ffe, 3'b000, 8'd3);
        cmp15("pc", 15'h7ffe, pc_o);
        cmp8("push low", 8'h89, u_mem.dmem[8'h2d]);
        cmp8("push high", 8'h67, u_mem.dmem[8'h2c]);
        cmp8("stack", 8'h2b, stack_ptr_o);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        cmp8("acc", 8'h00, acc_o);
        cmp8("first_ptr", 8'h00, first_ptr_o);
        cmp8("stack", 8'h2f, stack_ptr_o);
        cmp15("pc", 15'h0000, pc_o);
        cmp8("psw", 8'h00, 8'(psw_o));
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_ptr();
        t_mem();
        t_rom();
        t_rel();
        t_abs();
        end_of_test();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #40us;
        mismatches++;
        end_of_test();
    end
endmodule

`default_nettype wire
